// [inc/irq_pend_pkg.sv]
// constants for the interrupt pending register block
// assumes a 32-bit AXI4-Lite register port and eight interrupt sources
package irq_pend_pkg;

    // ========================================================================
    // register indices (byte address is four times the index)
    localparam logic [9:0] pend_index   = 10'h0da;
    localparam logic [9:0] status_index = 10'h0dc;
    localparam logic [9:0] mask_index   = 10'h0dd;

    // ========================================================================
    // widths and reset values
    localparam int         src_count    = 8;
    localparam logic [7:0] pend_reset   = 8'h00;
    localparam logic [7:0] status_reset = 8'h00;
    localparam logic [7:0] mask_reset   = 8'h00;

    // ========================================================================
    // source bit positions
    localparam int bit_voltage_monitor = 0;
    localparam int bit_analog          = 1;
    localparam int bit_touch_sense     = 2;
    localparam int bit_first_timer     = 3;
    localparam int bit_gpio            = 4;
    localparam int bit_spi             = 5;
    localparam int bit_sleep_timer     = 6;
    localparam int bit_i2c             = 7;

    // ========================================================================
    // bus answers
    localparam logic [1:0] resp_okay   = 2'h0;
    localparam logic [1:0] resp_decerr = 2'h3;

endpackage

// [inc/pend_ctl_if.sv]
// signals between the bus front end and the pending bit array
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface pend_ctl_if;
    logic       wr_strobe;
    logic [7:0] wr_data;
    logic       sw_enable;
    logic [7:0] hw_request;
    logic [7:0] pending;
    logic [7:0] post_event;

    modport front (output wr_strobe, output wr_data, output sw_enable,
                   output hw_request, input pending, input post_event);
    modport bits  (input wr_strobe, input wr_data, input sw_enable,
                   input hw_request, output pending, output post_event);
endinterface

// [verilog/pend_bits.sv]
// eight posted-interrupt bits with hardware post, software post and clear
// assumes write strobe is a one-cycle pulse on aclk
`timescale 1ns/1ps
module pend_bits
(
    // clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic ce,
    // control
    pend_ctl_if.bits  ctl
);

    // ========================================================================
    // per-source bit
    genvar g;
    generate
        for (g = 0; g < irq_pend_pkg::src_count; g++)
        begin : g_bit
            logic set_bit;
            logic clr_bit;
            // software post only with enable and a one
            assign set_bit = ctl.hw_request[g]
                             | (ctl.wr_strobe & ctl.sw_enable & ctl.wr_data[g]); // RULE4
            // clear only without enable and with a zero
            assign clr_bit = ctl.wr_strobe & ~ctl.sw_enable & ~ctl.wr_data[g]; // RULE2

            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                begin
                    ctl.pending[g] <= irq_pend_pkg::pend_reset[g];
                end
                else if (ce)
                begin
                    // set wins over a clear in the same cycle
                    if (set_bit)
                    begin
                        ctl.pending[g] <= 1'b1;
                    end
                    else if (clr_bit)
                    begin
                        ctl.pending[g] <= 1'b0; // RULE3
                    end
                end
            end

            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                begin
                    ctl.post_event[g] <= 1'b0;
                end
                else if (ce)
                begin
                    ctl.post_event[g] <= set_bit & ~ctl.pending[g];
                end
            end
        end
    endgenerate

endmodule // pend_bits

// [verilog/interrupt_pending_clear_post.sv]
// AXI4-Lite front end of the interrupt pending register
// assumes source requests and the software enable come from aclk logic
//
// Functional notes
// RULE1 - reading the pending register shows a one for each posted source
// RULE2 - with software interrupts off, writing zero clears that source's posted interrupt
// RULE3 - clearing a bit with nothing posted changes no interrupt state
// RULE4 - with software interrupts on, writing one posts that source's interrupt
// RULE5 - write one with enable off, or zero with enable on, does nothing
// RULE6 - bits 7..0: i2c, sleep timer, spi, gpio, timer 0, touch, analog, monitor
// RULE7 - software interrupt enable is one input choosing clear or post writes
`timescale 1ns/1ps
module interrupt_pending_clear_post
(
    // clock, reset, enable
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        ce,
    // write address channel
    input  wire logic [31:0] awaddr,
    input  wire logic [2:0]  awprot,
    input  wire logic        awvalid,
    output      logic        awready,
    // write data channel
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output      logic        wready,
    // write response channel
    output      logic [1:0]  bresp,
    output      logic        bvalid,
    input  wire logic        bready,
    // read address channel
    input  wire logic [31:0] araddr,
    input  wire logic [2:0]  arprot,
    input  wire logic        arvalid,
    output      logic        arready,
    // read data channel
    output      logic [31:0] rdata,
    output      logic [1:0]  rresp,
    output      logic        rvalid,
    input  wire logic        rready,
    // interrupt sources and control
    input  wire logic        i2c_request,
    input  wire logic        sleep_timer_request,
    input  wire logic        spi_request,
    input  wire logic        gpio_request,
    input  wire logic        first_timer_source,
    input  wire logic        touch_sense_request,
    input  wire logic        analog_request,
    input  wire logic        voltage_monitor_request,
    input  wire logic        sw_interrupt_enable,
    // outputs
    output      logic [7:0]  pending_irq,
    output      logic        irq
);

    // ========================================================================
    // address decode
    function automatic logic [9:0] reg_index(input logic [31:0] addr);
        reg_index = addr[11:2];
    endfunction

    function automatic logic is_mapped(input logic [31:0] addr);
        logic [9:0] idx;
        idx = reg_index(addr);
        if (addr[31:12] != 20'h00000)
            is_mapped = 1'b0;
        else if (idx == irq_pend_pkg::pend_index)
            is_mapped = 1'b1;
        else if (idx == irq_pend_pkg::status_index)
            is_mapped = 1'b1;
        else if (idx == irq_pend_pkg::mask_index)
            is_mapped = 1'b1;
        else
            is_mapped = 1'b0;
    endfunction

    // ========================================================================
    // state
    pend_ctl_if  ctl ();
    logic [31:0] aw_addr;
    logic        aw_full;
    logic [7:0]  w_byte;
    logic        w_lane0;
    logic        w_full;
    logic        do_write;
    logic        wr_ok;
    logic [7:0]  status;
    logic [7:0]  mask;

    assign do_write = aw_full & w_full & ~bvalid;
    assign wr_ok    = do_write & is_mapped(aw_addr) & w_lane0;

    // ========================================================================
    // write channels
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awready <= 1'b0;
            aw_full <= 1'b0;
            aw_addr <= 32'h00000000;
        end
        else if (ce)
        begin
            if (awready && awvalid)
            begin
                awready <= 1'b0;
                aw_full <= 1'b1;
                aw_addr <= awaddr;
            end
            else if (do_write)
            begin
                aw_full <= 1'b0;
            end
            else if (!aw_full && !bvalid)
            begin
                awready <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wready  <= 1'b0;
            w_full  <= 1'b0;
            w_byte  <= 8'h00;
            w_lane0 <= 1'b0;
        end
        else if (ce)
        begin
            if (wready && wvalid)
            begin
                wready  <= 1'b0;
                w_full  <= 1'b1;
                w_byte  <= wdata[7:0];
                w_lane0 <= wstrb[0];
            end
            else if (do_write)
            begin
                w_full <= 1'b0;
            end
            else if (!w_full && !bvalid)
            begin
                wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid <= 1'b0;
            bresp  <= irq_pend_pkg::resp_okay;
        end
        else if (ce)
        begin
            if (do_write)
            begin
                bvalid <= 1'b1;
                bresp  <= is_mapped(aw_addr) ? irq_pend_pkg::resp_okay
                                             : irq_pend_pkg::resp_decerr;
            end
            else if (bvalid && bready)
            begin
                bvalid <= 1'b0;
            end
        end
    end

    // ========================================================================
    // read channels
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= 32'h00000000;
            rresp   <= irq_pend_pkg::resp_okay;
        end
        else if (ce)
        begin
            if (arready && arvalid)
            begin
                arready <= 1'b0;
                rvalid  <= 1'b1;
                rresp   <= is_mapped(araddr) ? irq_pend_pkg::resp_okay
                                             : irq_pend_pkg::resp_decerr;
                if (!is_mapped(araddr))
                    rdata <= 32'h00000000;
                else if (reg_index(araddr) == irq_pend_pkg::pend_index)
                    rdata <= {24'h000000, ctl.pending}; // RULE1
                else if (reg_index(araddr) == irq_pend_pkg::status_index)
                    rdata <= {24'h000000, status};
                else
                    rdata <= {24'h000000, mask};
            end
            else if (rvalid && rready)
            begin
                rvalid <= 1'b0;
            end
            else if (!rvalid)
            begin
                arready <= 1'b1;
            end
        end
    end

    // ========================================================================
    // pending bit array
    assign ctl.wr_strobe  = wr_ok & (reg_index(aw_addr) == irq_pend_pkg::pend_index);
    assign ctl.wr_data    = w_byte;
    assign ctl.sw_enable  = sw_interrupt_enable; // RULE5 RULE7
    assign ctl.hw_request = {i2c_request, sleep_timer_request, spi_request, gpio_request,
                             first_timer_source, touch_sense_request, analog_request,
                             voltage_monitor_request}; // RULE6

    pend_bits u_bits
    (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ce      (ce),
        .ctl     (ctl.bits)
    );

    assign pending_irq = ctl.pending;

    // ========================================================================
    // interrupt status, mask and output
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            status <= irq_pend_pkg::status_reset;
        end
        else if (ce)
        begin
            // new posts win over a write-one clear
            if (wr_ok && reg_index(aw_addr) == irq_pend_pkg::status_index)
                status <= (status & ~w_byte) | ctl.post_event;
            else
                status <= status | ctl.post_event;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            mask <= irq_pend_pkg::mask_reset;
        end
        else if (ce && wr_ok && reg_index(aw_addr) == irq_pend_pkg::mask_index)
        begin
            mask <= w_byte;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            irq <= 1'b0;
        end
        else if (ce)
        begin
            irq <= |(status & mask);
        end
    end

endmodule // interrupt_pending_clear_post

// [tb/irq_pend_props.sv]
// checker for the interrupt pending register block
// assumes a bind onto the top module, seeing its ports only
`timescale 1ns/1ps
module irq_pend_props
(
    // clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        ce,
    // bus
    input wire logic [31:0] awaddr,
    input wire logic        awvalid,
    input wire logic        awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0]  wstrb,
    input wire logic        wvalid,
    input wire logic        wready,
    input wire logic [1:0]  bresp,
    input wire logic        bvalid,
    input wire logic [31:0] araddr,
    input wire logic        arvalid,
    input wire logic        arready,
    input wire logic [31:0] rdata,
    input wire logic        rvalid,
    // sources and result
    input wire logic        i2c_request,
    input wire logic        sleep_timer_request,
    input wire logic        spi_request,
    input wire logic        gpio_request,
    input wire logic        first_timer_source,
    input wire logic        touch_sense_request,
    input wire logic        analog_request,
    input wire logic        voltage_monitor_request,
    input wire logic        sw_interrupt_enable,
    input wire logic [7:0]  pending_irq
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    localparam logic [31:0] pa = {20'h0, irq_pend_pkg::pend_index, 2'h0};
    wire logic [7:0] src = {i2c_request, sleep_timer_request, spi_request, gpio_request,
        first_timer_source, touch_sense_request, analog_request, voltage_monitor_request};
    logic [31:0] wa;
    logic [7:0]  wd;
    logic        ws;

    // ==========
    // last write address and data taken
    always_ff @(posedge aclk)
    begin
        if (awvalid && awready && ce)
            wa <= awaddr;
        if (wvalid && wready && ce)
        begin
            wd <= wdata[7:0];
            ws <= wstrb[0];
        end
    end

    // ==========
    // properties
    a_hw_post: assert property (ce && src != 8'h00 |=>
        (pending_irq & $past(src)) == $past(src)) else $error("request not posted");
    a_pend_read: assert property (arvalid && arready && ce && araddr == pa |=>
        rvalid && rdata == {24'h0, $past(pending_irq)}) else $error("bad read data");
    a_zero_clear: assert property ($rose(bvalid) && wa == pa && ws &&
        !$past(sw_interrupt_enable) |-> pending_irq == (($past(pending_irq) & wd) | $past(src)))
        else $error("bad clear");
    a_one_post: assert property ($rose(bvalid) && wa == pa && ws &&
        $past(sw_interrupt_enable) |-> pending_irq == ($past(pending_irq) | wd | $past(src)))
        else $error("bad post");
    a_no_set: assert property (!$rose(bvalid) |->
        (pending_irq & ~$past(pending_irq) & ~$past(src)) == 8'h00) else $error("stray set");
    a_no_clear: assert property ($past(aresetn) && !($rose(bvalid) && wa == pa) |->
        ($past(pending_irq) & ~pending_irq) == 8'h00) else $error("stray clear");
    a_pend_okay: assert property ($rose(bvalid) && wa == pa |->
        bresp == irq_pend_pkg::resp_okay) else $error("bad write answer");
    a_resp_hold: assert property (bvalid && !$rose(bvalid) |->
        $stable(bresp)) else $error("answer changed");
endmodule // irq_pend_props

// [tb/interrupt_pending_clear_post_tb_top.sv]
// self-checking bench for the interrupt pending register block
// assumes the package and the checker are compiled first
`timescale 1ns/1ps
module interrupt_pending_clear_post_tb_top;
    localparam logic [31:0] pa = {20'h0, irq_pend_pkg::pend_index, 2'h0};
    localparam logic [31:0] sa = {20'h0, irq_pend_pkg::status_index, 2'h0};
    localparam logic [31:0] ma = {20'h0, irq_pend_pkg::mask_index, 2'h0};
    logic aclk = 1'h0, aresetn = 1'h0, ce = 1'h1, sw = 1'h0, irq;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, d, q;
    logic [2:0] awprot = 3'h0, arprot = 3'h0;
    logic [3:0] wstrb = 4'h0;
    logic [1:0] bresp, rresp, r;
    logic [7:0] src = 8'h0, pending_irq, pend = 8'h0, st = 8'h0, mask = 8'h0;
    int fail_count = 0, total_checks = 0, seed = 13315, cyc = 0;

    always #12.5 aclk = ~aclk;

    interrupt_pending_clear_post uut
    (
        .aclk(aclk), .aresetn(aresetn), .ce(ce),
        .awaddr(awaddr), .awprot(awprot), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arprot(arprot), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .pending_irq(pending_irq), .irq(irq),
        .i2c_request(src[7]), .sleep_timer_request(src[6]), .spi_request(src[5]),
        .gpio_request(src[4]), .first_timer_source(src[3]), .touch_sense_request(src[2]),
        .analog_request(src[1]), .voltage_monitor_request(src[0]), .sw_interrupt_enable(sw)
    );

    // ==========
    // helpers
    function automatic logic [7:0] after(logic [7:0] p, logic [7:0] v, logic s);
        return s ? p | v : p & v;
    endfunction

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(string n, logic [31:0] e, logic [31:0] s);
        total_checks++;
        if (s !== e)
        begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask

    // one write (w high) or one read; handshakes judged at the falling edge
    task automatic bus(logic w, logic [31:0] a, logic [31:0] v, logic [3:0] s);
        logic ha, hw, hb, hs, hr;
        @(posedge aclk);
        {awaddr, araddr, wdata, wstrb} <= {a, a, v, s};
        {awvalid, wvalid, bready, arvalid, rready} <= {w, w, w, !w, !w};
        do
        begin
            @(negedge aclk);
            {ha, hw, hb} = {awready & awvalid, wready & wvalid, bvalid & bready};
            {hs, hr} = {arready & arvalid, rvalid & rready};
            if (hb)
                r = bresp;
            if (hr)
                {r, d} = {rresp, rdata};
            @(posedge aclk);
            {awvalid, wvalid, bready} <= {awvalid & !ha, wvalid & !hw, bready & !hb};
            {arvalid, rready} <= {arvalid & !hs, rready & !hr};
        end
        while (awvalid | wvalid | bready | arvalid | rready);
    endtask

    task automatic look();
        bus(1'h0, pa, 32'h0, 4'h0);
        chk("pending", {24'h0, pend}, d);
        chk("rresp", {30'h0, irq_pend_pkg::resp_okay}, {30'h0, r});
        chk("pending_irq", {24'h0, pend}, {24'h0, pending_irq});
        bus(1'h0, sa, 32'h0, 4'h0);
        chk("status", {24'h0, st}, d);
        chk("irq", {31'h0, |(st & mask)}, {31'h0, irq});
    endtask

    task automatic pulse(logic [7:0] b);
        @(posedge aclk);
        src <= b;
        @(posedge aclk);
        src <= 8'h0;
        st = st | (b & ~pend);
        pend = pend | b;
    endtask

    task automatic wp(logic [7:0] v, logic s, logic e);
        @(posedge aclk);
        sw <= s;
        bus(1'h1, pa, {24'h0, v}, {3'h0, e});
        if (e)
        begin
            st = st | (s ? v & ~pend : 8'h0);
            pend = after(pend, v, s);
        end
    endtask

    always @(posedge aclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fail_count++;
            wrap_up();
        end
    end

    // ==========
    // tests
    initial
    begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'h1;
        bus(1'h0, ma, 32'h0, 4'h0);
        chk("mask", 32'h0, d);
        look();
        $display("test reset done");
        // requests while the enable is low must not post
        @(posedge aclk);
        {ce, src} <= {1'h0, 8'h81};
        @(posedge aclk);
        {ce, src} <= {1'h1, 8'h00};
        look();
        $display("test enable done");
        for (int i = 0; i < 8; i++)
        begin
            pulse(8'h01 << i);
            wp(8'h00, 1'h1, 1'h1);
            wp(8'hff, 1'h0, 1'h1);
            bus(1'h1, ma, {24'h0, 8'h01 << i}, 4'h1);
            mask = 8'h01 << i;
            look();
            wp(~(8'h01 << i), 1'h0, 1'h1);
            wp(~(8'h01 << i), 1'h0, 1'h1);
            bus(1'h1, sa, {24'h0, st}, 4'h1);
            st = 8'h0;
            wp(8'h01 << i, 1'h1, 1'h0);
            look();
            wp(8'h01 << i, 1'h1, 1'h1);
            look();
        end
        $display("test sources done");
        bus(1'h1, pa + 32'h4, 32'h0, 4'h1);
        chk("bresp", {30'h0, irq_pend_pkg::resp_decerr}, {30'h0, r});
        bus(1'h0, pa + 32'h4, 32'h0, 4'h0);
        chk("unmapped", 32'h0, d);
        chk("rresp", {30'h0, irq_pend_pkg::resp_decerr}, {30'h0, r});
        $display("test unmapped done");
        for (int i = 0; i < 250; i++)
        begin
            q = $random(seed);
            case (q[1:0])
                2'h0: pulse(q[15:8]);
                2'h1: wp(q[15:8], q[2], q[3]);
                2'h2:
                begin
                    bus(1'h1, q[2] ? ma : sa, {24'h0, q[23:16]}, 4'h1);
                    if (q[2])
                        mask = q[23:16];
                    else
                        st = st & ~q[23:16];
                end
                default: look();
            endcase
        end
        $display("test random done");
        wrap_up();
    end
endmodule // interrupt_pending_clear_post_tb_top

bind interrupt_pending_clear_post irq_pend_props props
(
    .aclk(aclk), .aresetn(aresetn), .ce(ce),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rvalid(rvalid),
    .i2c_request(i2c_request), .sleep_timer_request(sleep_timer_request),
    .spi_request(spi_request), .gpio_request(gpio_request),
    .first_timer_source(first_timer_source), .touch_sense_request(touch_sense_request),
    .analog_request(analog_request), .voltage_monitor_request(voltage_monitor_request),
    .sw_interrupt_enable(sw_interrupt_enable), .pending_irq(pending_irq)
);
